// ---- common/clk_dly_cfg.svh ----
// Constants for the group digital delay and output alignment block.
// Overview of operation
// - Any group may lead or lag another by up to 517.5 distribution periods.
// - Effective group delay spans 4.5 to 522 periods, relative offset 0 to 517.5.
// - Effective delay is the count, 5 to 522, minus half when half-step set.
// - A new delay count takes effect only at an alignment event, non-exempt groups.
// - Half-step changes move the output phase at once, with no alignment event.
// - One delay step is one distribution clock period.
// - Delay counters run on the distribution clock; every divide setting gives the same step.
// - After alignment, participating groups hold a fixed phase set by their delays.
// - A persisting alignment request holds participating outputs low.
// - Sync-exempt groups ignore alignment events and keep toggling.
// - Alignment requests act only while the alignment enable bit is set.
// - Reference-fed outputs are not aligned with distribution-fed outputs.
// - The reference buffer output always comes from the reference oscillator input.
// - Each upper channel takes distribution or reference clock by its source select.
// - Sync-exempt works normally for upper channels fed from the distribution path.
// - Upper channels align normally when fed from the distribution path.
// - Held low during request; on release outputs rise together unless delays differ.
// - Each output rises 6 cycles plus its delay after the registered release.
`ifndef CLK_DLY_CFG_SVH
`define CLK_DLY_CFG_SVH
`define NUM_GROUPS        7
`define UPPER_LO          3
`define UPPER_HI          4
`define ADDR_W            8
`define ADDR_CTRL         8'h00
`define ADDR_STATUS       8'h04
`define ADDR_GRP_BASE     8'h10
`define CTRL_SYNC_EN_BIT  0
`define CTRL_SOFT_REQ_BIT 1
`define STAT_REQ_BIT      8
`define GRP_DLY_LSB       0
`define GRP_DLY_MSB       9
`define GRP_HS_BIT        10
`define GRP_EXEMPT_BIT    11
`define GRP_SRC_BIT       12
`define GRP_DIV_LSB       16
`define GRP_DIV_MSB       23
`define DLY_MIN           10'h005
`define DLY_MAX           10'h20a
`define DLY_RST           10'h005
`define DIV_RST           8'h01
`define SYNC_FIXED_CYCLES 6
`define SYNC_PIPE_CYCLES  4
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`endif

// ---- common/clk_dly_pkg.sv ----
// Types shared by the group delay block.
package clk_dly_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_ASSERT, ST_HOLD, ST_WAIT} chan_state_t;
  typedef logic [9:0] delay_count_t;
  typedef logic [7:0] divide_t;
endpackage

// ---- hdl/clock_output_digital_delay_sync.sv ----
// Top of the group delay and alignment block with its register slave.
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "clk_dly_cfg.svh"
module clock_output_digital_delay_sync (
  // Distribution clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // Write address channel
  input  wire logic [`ADDR_W-1:0]         awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  // Write data channel
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  // Write response channel
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // Read address channel
  input  wire logic [`ADDR_W-1:0]         araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  // Read data channel
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // Alignment request pin
  input  wire logic                       sync_request_pin,
  // Reference oscillator path
  input  wire logic                       reference_oscillator_input,
  output logic                            reference_buffer_output,
  // Group outputs, two half-period samples per group
  output logic [2*`NUM_GROUPS-1:0]        group_out
);
  localparam int NG = `NUM_GROUPS;

  logic                        awready_q;
  logic                        wready_q;
  logic                        bvalid_q;
  logic [1:0]                  bresp_q;
  logic                        arready_q;
  logic                        rvalid_q;
  logic [31:0]                 rdata_q;
  logic [1:0]                  rresp_q;
  logic                        ctrl_sync_en_q;
  logic                        ctrl_soft_req_q;
  logic                        sync_s1_q;
  logic                        sync_s2_q;
  logic                        req_q;
  logic                        ref_s1_q;
  logic                        ref_s2_q;
  logic                        ref_buf_q;
  logic [2*NG-1:0]             group_out_q;
  clk_dly_pkg::delay_count_t   grp_dly_q [NG];
  clk_dly_pkg::divide_t        grp_div_q [NG];
  logic [NG-1:0]               grp_hs_q;
  logic [NG-1:0]               grp_exempt_q;
  logic [NG-1:0]               grp_src_q;
  logic [NG-1:0]               grp_req;
  logic [NG-1:0]               grp_held;
  logic [NG-1:0]               grp_wsel;
  logic [2*NG-1:0]             chan_out;
  logic                        wr_en;
  logic                        rd_en;
  logic                        wr_hit;
  logic [31:0]                 wmask;
  logic [31:0]                 ctrl_word;
  logic [31:0]                 ctrl_new;
  logic [31:0]                 status_word;
  logic [31:0]                 grp_word [NG];
  logic [31:0]                 rd_word;
  logic                        rd_hit;

  assign awready                 = awready_q;
  assign wready                  = wready_q;
  assign bvalid                  = bvalid_q;
  assign bresp                   = bresp_q;
  assign arready                 = arready_q;
  assign rvalid                  = rvalid_q;
  assign rdata                   = rdata_q;
  assign rresp                   = rresp_q;
  assign reference_buffer_output = ref_buf_q;
  assign group_out               = group_out_q;

  // Address and data are taken together in the cycle both readies are high.
  assign wr_en = awready_q && awvalid && wready_q && wvalid;
  assign rd_en = arready_q && arvalid;
  assign wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [31:0] m);
    merge = (old_w & ~m) | (new_w & m);
  endfunction

  function automatic clk_dly_pkg::delay_count_t clamp_dly(input logic [31:0] w);
    clk_dly_pkg::delay_count_t d;
    d = w[`GRP_DLY_MSB:`GRP_DLY_LSB];
    if (d < `DLY_MIN)
      clamp_dly = `DLY_MIN;
    else if (d > `DLY_MAX)
      clamp_dly = `DLY_MAX;
    else
      clamp_dly = d;
  endfunction

  assign ctrl_word   = {30'h0, ctrl_soft_req_q, ctrl_sync_en_q};
  assign ctrl_new    = merge(ctrl_word, wdata, wmask);
  assign status_word = {23'h0, req_q, 1'b0, grp_held};
  assign wr_hit      = (awaddr == `ADDR_CTRL) || (awaddr == `ADDR_STATUS) || (|grp_wsel);

  // Write address and data handshake.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end
    else if (awready_q)
    begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end
    else if (awvalid && wvalid && !bvalid_q)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
    end
  end

  // Write response.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end
    else if (wr_en)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // Control register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_sync_en_q  <= 1'b0;
      ctrl_soft_req_q <= 1'b0;
    end
    else if (wr_en && awaddr == `ADDR_CTRL)
    begin
      ctrl_sync_en_q  <= ctrl_new[`CTRL_SYNC_EN_BIT];
      ctrl_soft_req_q <= ctrl_new[`CTRL_SOFT_REQ_BIT];
    end
  end

  // Pin request synchroniser; the requester holds it over a clock period.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
    end
    else
    begin
      sync_s1_q <= sync_request_pin;
      sync_s2_q <= sync_s1_q;
    end
  end

  // Registered request; the release is registered at the edge where it falls.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      req_q <= 1'b0;
    else
      req_q <= ctrl_sync_en_q && (sync_s2_q || ctrl_soft_req_q);
  end

  // Reference buffer is fed only by the reference input.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_s1_q  <= 1'b0;
      ref_s2_q  <= 1'b0;
      ref_buf_q <= 1'b0;
    end
    else
    begin
      ref_s1_q  <= reference_oscillator_input;
      ref_s2_q  <= ref_s1_q;
      ref_buf_q <= ref_s2_q;
    end
  end

  generate
    for (genvar g = 0; g < NG; g++)
    begin : gen_grp
      localparam logic [`ADDR_W-1:0] GADDR = `ADDR_W'(`ADDR_GRP_BASE + 4 * g);
      localparam bit UPPER = (g >= `UPPER_LO) && (g <= `UPPER_HI);
      logic [31:0] gw;

      assign grp_word[g] = {8'h00, grp_div_q[g], 3'h0, grp_src_q[g], grp_exempt_q[g], grp_hs_q[g],
                            grp_dly_q[g]};
      assign grp_wsel[g] = (awaddr == GADDR);
      assign gw          = merge(grp_word[g], wdata, wmask);

      // Group settings; delay is kept within the legal count range.
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          grp_dly_q[g]    <= `DLY_RST;
          grp_hs_q[g]     <= 1'b0;
          grp_exempt_q[g] <= 1'b0;
          grp_src_q[g]    <= 1'b0;
          grp_div_q[g]    <= `DIV_RST;
        end
        else if (wr_en && grp_wsel[g])
        begin
          grp_dly_q[g]    <= clamp_dly(gw);
          grp_hs_q[g]     <= gw[`GRP_HS_BIT];
          grp_exempt_q[g] <= gw[`GRP_EXEMPT_BIT];
          grp_src_q[g]    <= UPPER ? gw[`GRP_SRC_BIT] : 1'b0;
          grp_div_q[g]    <= gw[`GRP_DIV_MSB:`GRP_DIV_LSB];
        end
      end

      // Exempt groups and reference-fed upper groups never see the request.
      assign grp_req[g] = req_q && !grp_exempt_q[g] && !grp_src_q[g];

      group_delay_channel u_chan (
        .clk    (aclk),
        .rst_n  (aresetn),
        .req    (grp_req[g]),
        .ddly   (grp_dly_q[g]),
        .hs     (grp_hs_q[g]),
        .divide (grp_div_q[g]),
        .out_q  (chan_out[2*g +: 2]),
        .held_q (grp_held[g])
      );

      // Upper groups may take the reference clock instead of the delay path.
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          group_out_q[2*g +: 2] <= 2'b00;
        else if (grp_src_q[g])
          group_out_q[2*g +: 2] <= {2{ref_s2_q}};
        else
          group_out_q[2*g +: 2] <= chan_out[2*g +: 2];
      end

      a_exempt_free: assert property (@(posedge aclk) disable iff (!aresetn)
        grp_exempt_q[g] && !grp_held[g] |=> !grp_held[g])
        else $error("exempt group left run state");
      if (UPPER)
      begin : gen_upper
        a_upper_source: assert property (@(posedge aclk) disable iff (!aresetn)
          grp_src_q[g] |=> group_out_q[2*g +: 2] == {2{$past(ref_s2_q)}})
          else $error("upper group not fed from reference");
      end
    end
  endgenerate

  // Read decode.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (araddr == `ADDR_CTRL)
      rd_word = ctrl_word;
    else if (araddr == `ADDR_STATUS)
      rd_word = status_word;
    else
    begin
      rd_hit = 1'b0;
      for (int i = 0; i < NG; i++)
      begin
        if (araddr == `ADDR_W'(`ADDR_GRP_BASE + 4 * i))
        begin
          rd_word = grp_word[i];
          rd_hit  = 1'b1;
        end
      end
    end
  end

  // Read address handshake.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      arready_q <= 1'b0;
    else if (arready_q)
      arready_q <= 1'b0;
    else if (arvalid && !rvalid_q)
      arready_q <= 1'b1;
  end

  // Read data.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `RESP_OKAY;
    end
    else if (rd_en)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  a_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_sync_en_q |=> !req_q)
    else $error("request passed while alignment disabled");
  a_sync_pipe: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ctrl_sync_en_q) && !$past(ctrl_soft_req_q) |-> req_q == $past(sync_request_pin, 3))
    else $error("pin request not seen three edges later");
  a_ref_buffer: assert property (@(posedge aclk) disable iff (!aresetn)
    ##3 ref_buf_q == $past(reference_oscillator_input, 3))
    else $error("reference buffer not following reference input");
  a_unmapped_err: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && !wr_hit |=> bvalid_q && bresp_q == `RESP_SLVERR)
    else $error("unmapped write not answered with error");
endmodule // clock_output_digital_delay_sync
`default_nettype wire

// ---- hdl/group_delay_channel.sv ----
// One output group: divider, alignment hold and release delay, half-step phase.
`timescale 1ns/1ps
`default_nettype none
`include "clk_dly_cfg.svh"
module group_delay_channel (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Gated request and settings
  input  wire logic                    req,
  input  wire clk_dly_pkg::delay_count_t ddly,
  input  wire logic                    hs,
  input  wire clk_dly_pkg::divide_t    divide,
  // Output halves and state
  output logic [1:0]                   out_q,
  output logic                         held_q
);
  localparam clk_dly_pkg::delay_count_t LOAD = 10'(`SYNC_FIXED_CYCLES - `SYNC_PIPE_CYCLES);
  clk_dly_pkg::chan_state_t state_q, state_d;
  clk_dly_pkg::delay_count_t cnt_q, cnt_d;
  clk_dly_pkg::divide_t     div_q, div_d, div_m1;
  logic                     lvl_q, lvl_d;

  assign div_m1 = (divide == 8'h00) ? 8'h00 : 8'(divide - 8'h01);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    div_d   = div_q;
    lvl_d   = lvl_q;
    if (div_q == div_m1)
    begin
      div_d = 8'h00;
      lvl_d = ~lvl_q;
    end
    else
    begin
      div_d = 8'(div_q + 8'h01);
    end
    unique case (state_q)
      clk_dly_pkg::ST_RUN:
        if (req)
        begin
          state_d = clk_dly_pkg::ST_ASSERT;
          cnt_d   = LOAD;
        end
      clk_dly_pkg::ST_ASSERT:
        if (!req)
        begin
          state_d = clk_dly_pkg::ST_WAIT;
          cnt_d   = 10'(ddly + LOAD);
          lvl_d   = 1'b0;
        end
        else if (cnt_q == 10'h000)
        begin
          state_d = clk_dly_pkg::ST_HOLD;
          lvl_d   = 1'b0;
        end
        else
        begin
          cnt_d = 10'(cnt_q - 10'h001);
        end
      clk_dly_pkg::ST_HOLD:
      begin
        lvl_d = 1'b0;
        div_d = 8'h00;
        if (!req)
        begin
          state_d = clk_dly_pkg::ST_WAIT;
          cnt_d   = 10'(ddly + LOAD);
        end
      end
      clk_dly_pkg::ST_WAIT:
      begin
        lvl_d = 1'b0;
        div_d = 8'h00;
        if (req)
        begin
          state_d = clk_dly_pkg::ST_HOLD;
        end
        else if (cnt_q == 10'h000)
        begin
          state_d = clk_dly_pkg::ST_RUN;
          lvl_d   = 1'b1;
        end
        else
        begin
          cnt_d = 10'(cnt_q - 10'h001);
        end
      end
    endcase
  end

  // Counters run on the distribution clock.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= clk_dly_pkg::ST_RUN;
      cnt_q   <= 10'h000;
      div_q   <= 8'h00;
      lvl_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      div_q   <= div_d;
      lvl_q   <= lvl_d;
    end
  end

  // First half shows the level, the second half may already show the next one.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      out_q  <= 2'b00;
      held_q <= 1'b0;
    end
    else
    begin
      out_q  <= {lvl_q, hs ? lvl_d : lvl_q};
      held_q <= (state_d != clk_dly_pkg::ST_RUN);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_req_held;
    state_q == clk_dly_pkg::ST_RUN && req ##1 req [*3];
  endsequence

  a_hold_entry: assert property (s_req_held |=> state_q == clk_dly_pkg::ST_HOLD)
    else $error("group not held after request");
  a_hold_low: assert property (state_q == clk_dly_pkg::ST_HOLD [*2] |-> out_q == 2'b00)
    else $error("held group output not low");
  a_load_count: assert property (state_q == clk_dly_pkg::ST_HOLD && !req |=>
    state_q == clk_dly_pkg::ST_WAIT && cnt_q == 10'($past(ddly) + LOAD))
    else $error("release count not loaded from delay");
  a_wait_rise: assert property (state_q == clk_dly_pkg::ST_WAIT && cnt_q == 10'h000 && !req |=>
    lvl_q ##1 out_q[1])
    else $error("output did not rise after release count");
  a_half_equal: assert property (!hs |=> out_q[1] == out_q[0])
    else $error("halves differ without half step");
  a_no_req_run: assert property (state_q == clk_dly_pkg::ST_RUN && !req |=> state_q == clk_dly_pkg::ST_RUN)
    else $error("group left run without request");
endmodule // group_delay_channel
`default_nettype wire

// ---- tb/sync_source_model.sv ----
// Model of the alignment request source and the reference oscillator.
`timescale 1ns/1ps
`default_nettype none
module sync_source_model (
  // Clock
  input  wire logic aclk,
  // Request level from the bench
  input  wire logic go,
  // Pins toward the block
  output logic      sync_request_pin,
  output logic      reference_oscillator_input
);
  logic [1:0] hold_q;
  logic [2:0] div_q;
  initial hold_q = 2'h0;
  initial div_q = 3'h0;
  initial reference_oscillator_input = 1'b0;
  // The request stays up three cycles after the bench drops it.
  always @(posedge aclk)
  begin
    if (go)
      hold_q <= 2'h3;
    else if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
  end
  assign sync_request_pin = go | (hold_q != 2'h0);
  // The reference toggles every seven cycles, away from rising edges.
  always @(negedge aclk)
  begin
    div_q <= (div_q == 3'h6) ? 3'h0 : div_q + 3'h1;
    if (div_q == 3'h6)
      reference_oscillator_input <= ~reference_oscillator_input;
  end
endmodule // sync_source_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the group delay and alignment block.
`timescale 1ns/1ps
`default_nettype none
`include "clk_dly_cfg.svh"
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        go = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, v;
  logic        sync_request_pin, reference_oscillator_input, reference_buffer_output;
  logic [13:0] group_out;
  integer      seed = 32'h00a2;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cnt = 0;
  int          t0, r0, n, t, f;
  int          dly[7];
  int          hi[7];
  int          lo[7];

  always #25 aclk = ~aclk;
  always @(posedge aclk) cnt <= cnt + 1;

  clock_output_digital_delay_sync clock_output_digital_delay_sync_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .sync_request_pin, .reference_oscillator_input, .reference_buffer_output,
    .group_out
  );
  sync_source_model sync_source_model_inst (
    .aclk, .go, .sync_request_pin, .reference_oscillator_input
  );

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int k);
    if (k >= 60)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, 32'h0, 32'h1);
      print_verdict();
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 60; k++)
    begin
      @(posedge aclk);
      if (awready === 1'b1 && wready === 1'b1) break;
    end
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    tmo(k);
    for (k = 0; k < 60; k++)
    begin
      @(posedge aclk);
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(k);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 60; k++)
    begin
      @(posedge aclk);
      if (arready === 1'b1) break;
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    tmo(k);
    for (k = 0; k < 60; k++)
    begin
      @(posedge aclk);
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(k);
  endtask

  function automatic logic [7:0] ga(input int g);
    return `ADDR_GRP_BASE + 8'(4 * g);
  endfunction

  function automatic logic [31:0] gw(input int d, input logic hs, input logic ex, input logic src,
                                     input logic [7:0] dv);
    return {8'h00, dv, 3'h0, src, ex, hs, d[9:0]};
  endfunction

  function automatic int clampd(input int x);
    return (x < 5) ? 5 : ((x > 522) ? 522 : x);
  endfunction

  // Level of a group with half period 64 that first rose at cycle rise.
  function automatic logic lvl(input int now, input int rise);
    return ((now - rise) / 64) % 2 == 0;
  endfunction

  // Hold the request, check the held state, release and time each rise.
  task automatic align();
    int  k, m, g;
    logic p;
    go <= 1'b1;
    t = 0;
    @(posedge aclk);
    p = group_out[11];
    repeat (14)
    begin
      @(posedge aclk);
      t += (group_out[11] !== p);
      p = group_out[11];
    end
    chk(t >= 10, 1);
    for (g = 0; g < 7; g++)
      if (g != 3 && g != 5) chk(group_out[2*g +: 2], 2'b00);
    rd(`ADDR_STATUS, v, rs);
    chk(v, 32'h0000_0157);
    p = reference_oscillator_input;
    for (k = 0; k < 60 && reference_oscillator_input === p; k++) @(posedge aclk);
    tmo(k);
    cyc(4);
    chk(reference_buffer_output, reference_oscillator_input);
    chk(group_out[7:6], {2{reference_oscillator_input}});
    go <= 1'b0;
    for (k = 0; k < 60 && sync_request_pin !== 1'b0; k++) @(posedge aclk);
    tmo(k);
    t0 = cnt;
    for (g = 0; g < 7; g++)
    begin
      hi[g] = -1;
      lo[g] = -1;
    end
    for (m = 0; m < 600; m++)
    begin
      for (g = 0; g < 7; g++)
      begin
        if (hi[g] < 0 && group_out[2*g+1] === 1'b1) hi[g] = m;
        if (lo[g] < 0 && group_out[2*g] === 1'b1) lo[g] = m;
      end
      @(posedge aclk);
    end
  endtask

  initial
  begin
    cyc(20);
    aresetn <= 1'b1;
    cyc(2);
    rd(ga(0), v, rs);
    chk(v, gw(5, 1'b0, 1'b0, 1'b0, 8'h01));
    rd(8'hfc, v, rs);
    chk(rs, `RESP_SLVERR);
    wr(8'hfc, 32'h0, rs);
    chk(rs, `RESP_SLVERR);
    wr(ga(1), 32'h3ff, rs);
    rd(ga(1), v, rs);
    chk(v[9:0], clampd(1023));
    wr(ga(1), 32'h0, rs);
    rd(ga(1), v, rs);
    chk(v[9:0], clampd(0));
    wstrb <= 4'h2;
    wr(ga(1), 32'hffff_ffff, rs);
    wstrb <= 4'hf;
    chk(rs, `RESP_OKAY);
    rd(ga(1), v, rs);
    chk(v, gw(clampd(32'h305), 1'b1, 1'b1, 1'b0, 8'h00));
    for (n = 0; n < 7; n++) dly[n] = 5 + ($unsigned($random(seed)) % 40);
    dly[1] = 522;
    dly[4] = 5;
    for (n = 0; n < 7; n++) wr(ga(n), gw(dly[n], n == 2, n == 5, n == 3, (n == 5) ? 8'h01 : 8'h40), rs);
    wr(`ADDR_CTRL, 32'h1, rs);
    chk(rs, `RESP_OKAY);
    align();
    for (n = 0; n < 7; n++)
      if (n != 3 && n != 5) chk(hi[n] - hi[4], dly[n] - dly[4]);
    chk((hi[4] - dly[4]) inside {9, 10}, 1);
    chk(lo[2], hi[2] - 1);
    chk(lo[0], hi[0]);
    r0 = t0 + hi[0];
    wr(ga(0), gw(dly[0] + 3, 1'b0, 1'b0, 1'b0, 8'h40), rs);
    repeat (3)
    begin
      cyc(37);
      chk(group_out[1], lvl(cnt, r0));
    end
    wr(ga(4), gw(5, 1'b1, 1'b0, 1'b0, 8'h40), rs);
    t = 0;
    f = 0;
    repeat (130)
    begin
      @(posedge aclk);
      t |= (group_out[9] !== group_out[8]);
      f |= (group_out[1] !== group_out[0]);
    end
    chk(t, 1);
    chk(f, 0);
    wr(`ADDR_CTRL, 32'h0, rs);
    go <= 1'b1;
    repeat (2)
    begin
      cyc(40);
      chk(group_out[1], lvl(cnt, r0));
    end
    go <= 1'b0;
    cyc(6);
    wr(`ADDR_CTRL, 32'h1, rs);
    align();
    chk(hi[0] - hi[4], dly[0] + 3 - dly[4]);
    chk(lo[4], hi[4] - 1);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
